/* File: core/idct_pkg.sv */
// Shared constants for the instruction decode and cycle timing block.
package idct_pkg;

    // Oscillator clocks in one instruction cycle.
    localparam int unsigned CLK_PER_ICYC = 4;

    // APB register byte offsets.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_WREG   = 8'h08;
    localparam logic [7:0] OFF_PTR0   = 8'h0C;
    localparam logic [7:0] OFF_PTR1   = 8'h10;
    localparam logic [7:0] OFF_INSTR  = 8'h14;
    localparam logic [7:0] OFF_COUNT  = 8'h18;
    localparam logic [7:0] OFF_FILE   = 8'h1C;

    // STATUS field positions.
    localparam int unsigned ST_CLASS = 0;
    localparam int unsigned ST_CYC   = 2;
    localparam int unsigned ST_BUSY  = 4;
    localparam int unsigned ST_C     = 5;
    localparam int unsigned ST_DC    = 6;
    localparam int unsigned ST_Z     = 7;

    // Values after reset.
    localparam logic [7:0]  RST_W   = 8'h00;
    localparam logic [15:0] RST_PTR = 16'h0000;

    // Instruction classes.
    typedef enum logic [1:0] {
        IDCT_CLS_BYTE = 2'h0,
        IDCT_CLS_BIT  = 2'h1,
        IDCT_CLS_LIT  = 2'h2
    } idct_class_e;

    // Byte and literal operation codes, bits 13:8.
    localparam logic [5:0] OP_MOVWF  = 6'h00;
    localparam logic [5:0] OP_CLR    = 6'h01;
    localparam logic [5:0] OP_SUBWF  = 6'h02;
    localparam logic [5:0] OP_DECF   = 6'h03;
    localparam logic [5:0] OP_IORWF  = 6'h04;
    localparam logic [5:0] OP_ANDWF  = 6'h05;
    localparam logic [5:0] OP_XORWF  = 6'h06;
    localparam logic [5:0] OP_ADDWF  = 6'h07;
    localparam logic [5:0] OP_MOVF   = 6'h08;
    localparam logic [5:0] OP_COMF   = 6'h09;
    localparam logic [5:0] OP_INCF   = 6'h0A;
    localparam logic [5:0] OP_DECREMENT_SKIP_ZERO = 6'h0B;
    localparam logic [5:0] OP_RRF    = 6'h0C;
    localparam logic [5:0] OP_RLF    = 6'h0D;
    localparam logic [5:0] OP_SWAPF  = 6'h0E;
    localparam logic [5:0] OP_INCREMENT_SKIP_ZERO = 6'h0F;
    localparam logic [5:0] OP_MOVLW  = 6'h30;
    localparam logic [5:0] OP_EXIT_WITH_LITERAL = 6'h34;
    localparam logic [5:0] OP_LSLF   = 6'h35;
    localparam logic [5:0] OP_LSRF   = 6'h36;
    localparam logic [5:0] OP_ASRF   = 6'h37;
    localparam logic [5:0] OP_SUBWFB = 6'h3B;
    localparam logic [5:0] OP_ADDWFC = 6'h3D;

    // Bit operation codes, bits 13:10.
    localparam logic [3:0] OP_BCF   = 4'h4;
    localparam logic [3:0] OP_BSF   = 4'h5;
    localparam logic [3:0] OP_SKIP_IF_BIT_CLEAR = 4'h6;
    localparam logic [3:0] OP_SKIP_IF_BIT_SET   = 4'h7;

    // Control operation codes.
    localparam logic [2:0]  OP_CALL   = 3'h4;
    localparam logic [2:0]  OP_ABSOLUTE_JUMP          = 3'h5;
    localparam logic [4:0]  OP_RELATIVE_BRANCH        = 5'h19;
    localparam logic [10:0] OP_MOVIW                  = 11'h002;
    localparam logic [10:0] OP_MOVWI                  = 11'h003;
    localparam logic [13:0] OP_RETURN                 = 14'h0008;
    localparam logic [13:0] OP_INTERRUPT_EXIT         = 14'h0009;
    localparam logic [13:0] OP_SUBROUTINE_JUMP_BY_ACC = 14'h000A;
    localparam logic [13:0] OP_BRANCH_BY_ACC          = 14'h000B;

endpackage

/* File: core/idct_phase_div.sv */
// Divider that marks the last oscillator clock of each instruction cycle.
module idct_phase_div
    import idct_pkg::*;
#(
    parameter int unsigned DIV = CLK_PER_ICYC
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    output logic      [1:0] o_phase,
    output logic            o_cyc_end
);

    ////////////////////////////////////////////////////////////////////////
    // Free running phase counter; the end pulse is registered so that it
    // lines up with the last phase rather than trailing it.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_phase   <= 2'h0;
            o_cyc_end <= 1'b0;
        end else begin
            o_phase   <= (o_phase == 2'(DIV - 1)) ? 2'h0 : o_phase + 2'h1;
            o_cyc_end <= (o_phase == 2'(DIV - 2));
        end
    end

endmodule

/* File: core/idct_core.sv */
// Instruction decoder with cycle timing, working register and APB access.
module idct_core
    import idct_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [13:0] i_instr_word,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             o_fetch_strobe,
    output logic             o_file_read,
    output logic      [1:0]  o_class,
    output logic      [1:0]  o_cycles
);

    logic        cyc_end;
    logic        run_reg;
    logic [7:0]  w_reg;
    logic        c_reg;
    logic        dc_reg;
    logic        z_reg;
    logic [15:0] ptr_reg [2];
    logic [13:0] instr_reg;
    logic [1:0]  wait_reg;
    logic [31:0] count_reg;
    logic [6:0]  faddr_reg;
    logic [7:0]  file_mem [128];
    logic        take;
    logic        apb_wr;
    logic        apb_setup;

    ////////////////////////////////////////////////////////////////////////
    // four-clock cycle divider
    idct_phase_div #(
        .DIV (CLK_PER_ICYC)
    ) u_div (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .o_phase   (),
        .o_cyc_end (cyc_end)
    );

    // A new word is taken only at a cycle end with no extra cycles pending.
    assign take      = cyc_end && run_reg && (wait_reg == 2'h0);
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pready && pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Field extraction from the single instruction word.
    logic [5:0] op6;
    logic [6:0] f_fld;
    logic       d_fld;
    logic [2:0] b_fld;
    logic       n_fld;
    logic [1:0] ptr_update_mode;
    logic [7:0] k_fld;
    assign op6    = i_instr_word[13:8];
    assign d_fld  = i_instr_word[7];
    assign f_fld  = i_instr_word[6:0];
    assign b_fld  = i_instr_word[9:7];
    assign ptr_update_mode = i_instr_word[1:0];
    assign k_fld  = i_instr_word[7:0];

    logic ctl0;
    logic byte_op;
    logic bit_op;
    logic ptr_mv;
    assign ctl0    = (op6 == OP_MOVWF) && !d_fld;
    assign byte_op = ((op6[5:4] == 2'h0) && !ctl0) || (op6 == OP_ADDWFC) ||
                     (op6 == OP_SUBWFB) || (op6 == OP_LSLF) || (op6 == OP_LSRF) ||
                     (op6 == OP_ASRF);
    assign bit_op  = (op6[5:4] == 2'h1);
    assign ptr_mv  = (i_instr_word[13:3] == OP_MOVIW) || (i_instr_word[13:3] == OP_MOVWI);

    ////////////////////////////////////////////////////////////////////////
    // Pointer selection and indirect address; file addresses 0 and 1 are
    // the two indirect access registers.
    logic        indir;
    logic [15:0] ptr_cur;
    logic [15:0] ptr_upd;
    logic [15:0] ptr_addr;
    logic [6:0]  eff_addr;
    logic        in_prog;
    logic [7:0]  rd_val;
    // pointer index picks 0 or 1
    assign n_fld    = ptr_mv ? i_instr_word[2] : f_fld[0];
    assign ptr_cur  = ptr_reg[n_fld];
    assign indir    = ptr_mv || ((byte_op || bit_op) && (f_fld[6:1] == 6'h00));
    // mode bit 0 picks decrement, bit 1 picks post update
    assign ptr_upd  = ptr_update_mode[0] ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
    assign ptr_addr = (ptr_mv && !ptr_update_mode[1]) ? ptr_upd : ptr_cur;
    assign in_prog  = indir && ptr_addr[15];
    assign eff_addr = indir ? ptr_addr[6:0] : f_fld;
    // Program memory is not reachable from here, so such reads give zero.
    assign rd_val   = in_prog ? 8'h00 : file_mem[eff_addr];

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic and routing for the word being taken.
    logic [7:0] res;
    logic       wr_f;
    logic       wr_w;
    logic       c_n;
    logic       dc_n;
    logic       upd_c;
    logic       upd_dc;
    logic       upd_z;
    logic       skip;
    logic [1:0] cyc_n;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opb;
    logic       cin;
    always_comb begin
        res    = rd_val;
        wr_f   = 1'b0;
        wr_w   = 1'b0;
        upd_c  = 1'b0;
        upd_dc = 1'b0;
        upd_z  = 1'b0;
        skip   = 1'b0;
        cyc_n  = 2'h1;
        // Subtraction adds the complement so one adder serves all four ops.
        opb    = (op6 == OP_SUBWF || op6 == OP_SUBWFB) ? ~w_reg : w_reg;
        cin    = (op6 == OP_SUBWF) || ((op6 == OP_ADDWFC || op6 == OP_SUBWFB) && c_reg);
        sum    = {1'b0, rd_val} + {1'b0, opb} + {8'h00, cin};
        nib    = {1'b0, rd_val[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        c_n    = sum[8];
        dc_n   = nib[4];
        if (byte_op) begin
            wr_f  = d_fld;
            wr_w  = !d_fld;
            upd_z = 1'b1;
            case (op6)
                OP_ADDWF, OP_ADDWFC, OP_SUBWF, OP_SUBWFB: begin
                    res    = sum[7:0];
                    upd_c  = 1'b1;
                    upd_dc = 1'b1;
                end
                OP_ANDWF: res = rd_val & w_reg;
                OP_IORWF: res = rd_val | w_reg;
                OP_XORWF: res = rd_val ^ w_reg;
                OP_COMF:  res = ~rd_val;
                OP_DECF:  res = rd_val - 8'h01;
                OP_INCF:  res = rd_val + 8'h01;
                // low don't-care bits of clear-accumulator ignored
                OP_CLR:   res = 8'h00;
                OP_MOVWF: begin
                    res   = w_reg;
                    upd_z = 1'b0;
                end
                OP_LSLF, OP_RLF: begin
                    res   = {rd_val[6:0], (op6 == OP_RLF) ? c_reg : 1'b0};
                    c_n   = rd_val[7];
                    upd_c = 1'b1;
                    upd_z = (op6 == OP_LSLF);
                end
                OP_LSRF, OP_ASRF, OP_RRF: begin
                    res   = {(op6 == OP_RRF) ? c_reg : (op6 == OP_ASRF) && rd_val[7],
                             rd_val[7:1]};
                    c_n   = rd_val[0];
                    upd_c = 1'b1;
                    upd_z = (op6 != OP_RRF);
                end
                OP_SWAPF: begin
                    res   = {rd_val[3:0], rd_val[7:4]};
                    upd_z = 1'b0;
                end
                // count skips cost a cycle only when skipping
                OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO: begin
                    res   = (op6 == OP_DECREMENT_SKIP_ZERO) ? rd_val - 8'h01 : rd_val + 8'h01;
                    skip  = (res == 8'h00);
                    upd_z = 1'b0;
                end
                default: res = rd_val;
            endcase
        end else if (bit_op) begin
            case (op6[5:2])
                OP_BCF: begin
                    res  = rd_val & ~(8'h01 << b_fld);
                    wr_f = 1'b1;
                end
                OP_BSF: begin
                    res  = rd_val | (8'h01 << b_fld);
                    wr_f = 1'b1;
                end
                OP_SKIP_IF_BIT_CLEAR: skip = !rd_val[b_fld];
                // The set-bit skip is the only code left in this class.
                default: skip = rd_val[b_fld];
            endcase
        end else if (ptr_mv) begin
            wr_f  = i_instr_word[3];
            wr_w  = !i_instr_word[3];
            res   = i_instr_word[3] ? w_reg : rd_val;
            upd_z = !i_instr_word[3];
        end else if (op6 == OP_MOVLW || op6 == OP_EXIT_WITH_LITERAL) begin
            res  = k_fld;
            wr_w = 1'b1;
        end
        if (skip) begin
            cyc_n = 2'h2;
        end
        if (i_instr_word[13:11] == OP_CALL || i_instr_word == OP_SUBROUTINE_JUMP_BY_ACC) begin
            cyc_n = 2'h2;
        end
        if (i_instr_word == OP_RETURN || i_instr_word == OP_INTERRUPT_EXIT ||
            op6 == OP_EXIT_WITH_LITERAL) begin
            cyc_n = 2'h2;
        end
        if (i_instr_word[13:11] == OP_ABSOLUTE_JUMP || i_instr_word[13:9] == OP_RELATIVE_BRANCH ||
            i_instr_word == OP_BRANCH_BY_ACC) begin
            cyc_n = 2'h2;
        end
        // extra cycle for indirect access into program memory
        if (in_prog) begin
            cyc_n = cyc_n + 2'h1;
        end
        // Writes aimed at program memory are dropped.
        if (in_prog) begin
            wr_f = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle sequencing: take, then burn the extra cycles.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wait_reg       <= 2'h0;
            instr_reg      <= 14'h0000;
            o_cycles       <= 2'h0;
            o_class        <= IDCT_CLS_BYTE;
            o_fetch_strobe <= 1'b0;
            o_file_read    <= 1'b0;
            count_reg      <= 32'h0000_0000;
        end else begin
            o_fetch_strobe <= take;
            // the target is read even when it is only written
            o_file_read    <= take && (byte_op || bit_op || ptr_mv);
            if (take) begin
                wait_reg  <= cyc_n - 2'h1;
                instr_reg <= i_instr_word;
                o_cycles  <= cyc_n;
                o_class   <= byte_op ? IDCT_CLS_BYTE : bit_op ? IDCT_CLS_BIT : IDCT_CLS_LIT;
                count_reg <= count_reg + 32'h0000_0001;
            end else if (cyc_end && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working register, flags and pointers; the core beats a same-cycle
    // software write so an executing instruction is never undone.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            w_reg      <= RST_W;
            c_reg      <= 1'b0;
            dc_reg     <= 1'b0;
            z_reg      <= 1'b0;
            ptr_reg[0] <= RST_PTR;
            ptr_reg[1] <= RST_PTR;
            run_reg    <= 1'b0;
        end else begin
            if (apb_wr && paddr == OFF_CTRL) begin
                run_reg <= pwdata[0];
            end
            if (take && wr_w) begin
                w_reg <= res;
            end else if (apb_wr && paddr == OFF_WREG) begin
                w_reg <= pwdata[7:0];
            end
            if (take && upd_c) begin
                c_reg <= c_n;
            end
            if (take && upd_dc) begin
                dc_reg <= dc_n;
            end
            if (take && upd_z) begin
                z_reg <= (res == 8'h00);
            end
            // pointer moves by one in the selected direction
            if (take && ptr_mv) begin
                ptr_reg[n_fld] <= ptr_upd;
            end else if (apb_wr && paddr == OFF_PTR0) begin
                ptr_reg[0] <= pwdata[15:0];
            end else if (apb_wr && paddr == OFF_PTR1) begin
                ptr_reg[1] <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modified value stored back to the file register
    always_ff @(posedge i_ref_clk) begin
        if (take && wr_f) begin
            file_mem[eff_addr] <= res;
        end else if (apb_wr && paddr == OFF_FILE) begin
            file_mem[pwdata[14:8]] <= pwdata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            faddr_reg <= 7'h00;
        end else if (apb_wr && paddr == OFF_FILE) begin
            faddr_reg <= pwdata[14:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: read data and ready are built in the setup cycle, so every
    // access completes in its first access cycle.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apb_setup) begin
                case (paddr)
                    OFF_CTRL:   prdata <= {31'h0, run_reg};
                    OFF_STATUS: prdata <= {24'h0, z_reg, dc_reg, c_reg, wait_reg != 2'h0,
                                           o_cycles, o_class};
                    OFF_WREG:   prdata <= {24'h0, w_reg};
                    OFF_PTR0:   prdata <= {16'h0, ptr_reg[0]};
                    OFF_PTR1:   prdata <= {16'h0, ptr_reg[1]};
                    OFF_INSTR:  prdata <= {18'h0, instr_reg};
                    OFF_COUNT:  prdata <= count_reg;
                    OFF_FILE:   prdata <= {17'h0, faddr_reg, file_mem[faddr_reg]};
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on timing and decode.
    sequence s_one_cyc_run;
        (o_fetch_strobe && o_cycles == 2'h1) ##1 run_reg [*3];
    endsequence

    property p_four_clk;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        cyc_end |=> !cyc_end [*3] ##1 cyc_end;
    endproperty
    a_four_clk: assert property (p_four_clk) else $error("Cycle end not every four clocks.");

    property p_single;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        s_one_cyc_run |=> o_fetch_strobe;
    endproperty
    a_single: assert property (p_single) else $error("One-cycle word not followed in four.");

    property p_call;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && i_instr_word[13:11] == OP_CALL && !in_prog) |=> o_cycles == 2'h2;
    endproperty
    a_call: assert property (p_call) else $error("Call not two cycles.");

    property p_ret;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && i_instr_word == OP_RETURN) |=> o_cycles == 2'h2 ##1 !o_fetch_strobe [*7];
    endproperty
    a_ret: assert property (p_ret) else $error("Return not two cycles.");

    property p_absolute_jump;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && i_instr_word[13:11] == OP_ABSOLUTE_JUMP) |=> o_cycles == 2'h2;
    endproperty
    a_absolute_jump: assert property (p_absolute_jump) else $error("Jump not two cycles.");

    property p_prog_extra;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && in_prog && byte_op && op6 == OP_MOVF) |=> o_cycles == 2'h2;
    endproperty
    a_prog_extra: assert property (p_prog_extra) else $error("No extra indirect cycle.");

    property p_rmw_read;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && byte_op) |=> o_file_read && o_class == IDCT_CLS_BYTE;
    endproperty
    a_rmw_read: assert property (p_rmw_read) else $error("File not read first.");

    property p_dest_w;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && op6 == OP_MOVF && !d_fld) |=> w_reg == $past(rd_val);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("Result not in accumulator.");

    property p_dec_skip;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && op6 == OP_DECREMENT_SKIP_ZERO && !indir && rd_val != 8'h01) |=>
            o_cycles == 2'h1;
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("Nonzero count skip not one cycle.");

    property p_pre_inc;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take && ptr_mv && ptr_update_mode == 2'h0) |=>
            ptr_reg[$past(n_fld)] == $past(ptr_cur) + 16'h0001;
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("Pointer not incremented.");

endmodule

/* File: bench/idct_prog_mem.sv */
// Program memory model that feeds instruction words to the decoder.
module idct_prog_mem (
    input  wire logic        i_ref_clk,
    input  wire logic        i_fetch_strobe,
    output logic      [13:0] o_instr_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] mem [0:63];
    logic [5:0]  idx = 6'h00;
    // Spare words are a bit set on a scratch file, so a late fetch changes no checked state.
    initial for (int i = 0; i < 64; i++) mem[i] = 14'h147F;
    // whole word
    // Step on only after the strobe, so the word holds through extra cycles.
    always @(posedge i_ref_clk) if (i_fetch_strobe) idx <= idx + 6'h01;
    assign o_instr_word = mem[idx];
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the instruction decoder and its cycle timing.
module tb
    import idct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata, rd, wv;
    logic        pready, pslverr, o_fetch_strobe, o_file_read, err;
    logic [1:0]  o_class, o_cycles;
    logic [13:0] i_instr_word;
    logic [7:0]  k, f;
    logic [8:0]  sum;
    logic [19:0] tab [20];
    logic [7:0]  offs [4] = '{OFF_CTRL, OFF_STATUS, OFF_WREG, OFF_PTR0};
    int          fails = 0, samples_checked = 0, cycles = 0, last = 0, n;
    idct_core idct_core_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_instr_word(i_instr_word), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .o_fetch_strobe(o_fetch_strobe), .o_file_read(o_file_read), .o_class(o_class),
        .o_cycles(o_cycles));
    idct_prog_mem idct_prog_mem_inst (.i_ref_clk(i_ref_clk), .i_fetch_strobe(o_fetch_strobe),
        .o_instr_word(i_instr_word));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz.
    always #12.5 i_ref_clk = ~i_ref_clk;
    // A hang ends the run as a mismatch.
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    // One APB transfer; the answer is read just after a rising edge, where it still shows
    // the values held at that edge, so request and data stand until pready is taken.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int m;
        m = 0;
        @(posedge i_ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            m++;
        end while (pready !== 1'b1 && m < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Each entry is word, class, cycles and file-read flag (2 means not checked).
    initial begin
        void'($urandom(23508));
        k = 8'($urandom);
        f = 8'h40 + 8'($urandom % 63);
        #1;
        tab = '{{14'h3411, 6'h28}, {14'h0008, 6'h28}, {14'h0009, 6'h28}, {14'h000A, 6'h28},
            {14'h000B, 6'h28}, {14'h2123, 6'h28}, {14'h2BFF, 6'h28}, {14'h3255, 6'h28},
            {14'h0BB0, 6'h09}, {14'h0BB1, 6'h05}, {14'h1832, 6'h19}, {14'h1C32, 6'h15},
            {14'h0012, 6'h2A}, {14'h0010, 6'h2A}, {14'h0801, 6'h09}, {14'h0103, 6'h06},
            {6'h30, k, 6'h24}, {7'h01, f[6:0], 6'h05}, {7'h0E, f[6:0], 6'h05}, {14'h147F, 6'h15}};
        for (int i = 0; i < 20; i++) idct_prog_mem_inst.mem[i] = tab[i][19:6];
        repeat (6) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        foreach (offs[j]) begin
            apb(1'b0, offs[j], 32'h0);
            check("reset value", rd, 32'h0); // cleared state
        end
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        wv = $urandom;
        apb(1'b1, OFF_WREG, wv);
        apb(1'b0, OFF_WREG, 32'h0);
        check("w readback", rd, {24'h0, wv[7:0]}); // accumulator
        apb(1'b1, OFF_FILE, 32'h3001);
        apb(1'b1, OFF_FILE, 32'h3105);
        apb(1'b1, OFF_FILE, 32'h3200);
        apb(1'b1, OFF_PTR0, 32'h8000);
        apb(1'b1, OFF_PTR1, 32'h8000);
        apb(1'b1, OFF_CTRL, 32'h1);
        for (int i = 0; i < 20; i++) begin
            n = 0;
            do begin
                @(posedge i_ref_clk);
                #1;
                n++;
            end while (o_fetch_strobe !== 1'b1 && n < 40);
            check("fetch strobe", 32'(o_fetch_strobe), 32'h1);
            check("class", 32'(o_class), 32'(tab[i][5:4])); // class
            check("cycles", 32'(o_cycles), 32'(tab[i][3:2]));
            if (tab[i][1:0] != 2'h2)
                check("file read", 32'(o_file_read), 32'(tab[i][1:0])); // read
            if (i > 0) check("spacing", cycles - last, 4 * tab[i - 1][3:2]); // period
            last = cycles;
        end
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b0, OFF_PTR0, 32'h0);
        check("pointer", rd, 32'h0000_8002);
        apb(1'b0, OFF_WREG, 32'h0);
        sum = k + k;
        check("add result", rd, {24'h0, sum[7:0]}); // routing
        apb(1'b0, OFF_STATUS, 32'h0);
        check("flags", rd, {24'h0, sum[7:0] == 0, (k[3:0] + k[3:0]) > 15, sum[8], 5'h05});
        tally_and_finish();
    end
endmodule
